// ==== rtl/sadc_ctrl.sv ====
// Purpose: Control logic around a 10-bit successive-approximation converter.
// Assumes: APB slave, single bus clock; analog comparator answers comp_i per bit.
// Notes: Conversion steps advance on conversion clock ticks derived from the selected clock source.
//
// Behaviour
// - Codes 00000-01011 pick pins 0..11; 01100-10100 connect ground.
// - Reserved codes give an undefined result; nothing is guaranteed.
// - Code 11011 picks bandgap, valid only with bandgap buffer enabled.
// - 11010 temperature, 11101 high ref, 11110 low ref, 11111 module off.
// - Clock source: bus, bus divided by two, alternate, local async.
// - Alternate clock comes from the external reference clock.
// - Conversion clock is source divided by divide field; software keeps range.
// - Alternate clock stays usable during wait mode.
// - Hardware trigger starts a conversion on each counter overflow.
// - Trigger works regardless of the counter's interrupt enable.
// - Trigger honoured in run, wait, stop3; synchronised before use.
// - Linear successive approximation producing 10 bits.
// - Result right-justified in 10-bit or 8-bit format.
// - Single and continuous modes; single returns to idle itself.
// - Completion flag with enableable interrupt request.
// - Optional compare, less-than or greater-or-equal, raises interrupt.
// - Sample time configurable with long option; speed/power settable.
// - Conversions run during wait and stop3.
// - Channel control write aborts and restarts unless channel all ones; with hardware trigger selected it aborts to idle.
// - Flag sets per conversion or on compare true; write or low-read clears.
// - All-ones channel powers down; no extra conversion after continuous.
// - One conversion per start unless continuous, which repeats back-to-back.
//
// Local design decisions: register access over APB and the register addresses.
module sadc_ctrl #(
   parameter int DIV_W = 2
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Clock sources and trigger
   input wire logic ext_reference_clock_i,
   input wire logic local_async_conv_clock_i,
   input wire logic hw_trigger_input_i,
   // Analog side
   input wire logic comp_i,
   output logic [9:0] dac_code_o,
   output sadc_pkg::sadc_route_type route_o,
   output logic sample_o,
   output logic long_sample_o,
   output logic low_power_o,
   // Interrupts
   output logic done_irq_o
);
   logic [7:0] chan_q, chan_d;
   logic hwtrg_q, hwtrg_d, cfe_q, cfe_d, cfgt_q, cfgt_d;
   logic [9:0] cmpv_q, cmpv_d;
   logic [7:0] cfg_q, cfg_d;
   logic bandgap_buffer_enable_q, bandgap_buffer_enable_d;
   logic done_q, done_d;
   logic [9:0] result_q, result_d;
   sadc_pkg::sadc_state_type state_q, state_d;
   logic [9:0] sar_q, sar_d;
   logic [3:0] bit_q, bit_d;
   logic [4:0] scnt_q, scnt_d;
   logic [7:0] divc_q, divc_d;
   logic half_q, half_d;
   logic [2:0] trg_sync_q;
   logic [2:0] alt_sync_q, asy_sync_q;
   logic [31:0] prdata_d;
   logic [9:0] dac_d;
   logic sample_d, irq_d;
   logic [2:0] trg_sync_d, alt_sync_d, asy_sync_d;
   logic long_d, lowp_d;
   sadc_pkg::sadc_route_type route_d;

   logic wr, rd, wr_chan, rd_result, trig_evt, src_tick, ck_tick, cmp_true, fin, off;
   logic acc, rd_setup, rdy_q, rdy_d;
   logic [1:0] src;
   logic [9:0] fin_res;

   function automatic logic [9:0] fmt_result(input logic [9:0] raw, input logic [1:0] mode);
      // Eight-bit mode keeps the top bits, right-justified.
      if (mode == sadc_pkg::SADC_MODE_8)
         return {2'h0, raw[9:2]};
      return raw;
   endfunction

   function automatic logic [4:0] sample_limit(input logic long_smp, input logic low_pwr);
      logic [4:0] base;
      base = long_smp ? sadc_pkg::SADC_SAMPLE_LONG : sadc_pkg::SADC_SAMPLE_SHORT;
      // High-speed mode adds settling ticks.
      if (!low_pwr)
         base = base + sadc_pkg::SADC_EXTRA_HISPD;
      return base;
   endfunction

   function automatic sadc_pkg::sadc_route_type decode_chan(input logic [4:0] ch, input logic bg);
      sadc_pkg::sadc_route_type r;
      r = '0;
      r.sel = ch;
      // Channel decode
      // Pins and ground
      r.pin_en = (ch <= sadc_pkg::SADC_CH_LAST_PIN);
      r.gnd_en = (ch > sadc_pkg::SADC_CH_LAST_PIN) && (ch <= sadc_pkg::SADC_CH_LAST_GND);
      r.temp_en = (ch == sadc_pkg::SADC_CH_TEMP);
      r.bandgap_en = (ch == sadc_pkg::SADC_CH_BANDGAP) && bg;
      r.vrefh_en = (ch == sadc_pkg::SADC_CH_VREFH);
      r.vrefl_en = (ch == sadc_pkg::SADC_CH_VREFL);
      r.powered = (ch != sadc_pkg::SADC_CH_OFF);
      return r;
   endfunction

   // A transfer takes effect only at the edge where ready is sampled high.
   assign acc = psel_i && penable_i && rdy_q;
   assign wr = acc && pwrite_i;
   assign rd = acc && !pwrite_i;
   // Read data is captured in the setup cycle so it stands through the access phase.
   assign rd_setup = psel_i && !penable_i && !pwrite_i;
   assign wr_chan = wr && (paddr_i == sadc_pkg::SADC_OFF_CTRL1);
   assign rd_result = rd && (paddr_i == sadc_pkg::SADC_OFF_RESULT);
   assign off = (chan_q[4:0] == sadc_pkg::SADC_CH_OFF);
   assign src = cfg_q[sadc_pkg::SADC_CLKSRC_LSB +: 2];

   assign trig_evt = trg_sync_q[1] && !trg_sync_q[2];

   // Source tick selection
   // Four sources
   always_comb
   begin
      unique case (src)
         sadc_pkg::SADC_CLK_BUS: src_tick = 1'b1;
         sadc_pkg::SADC_CLK_BUS2: src_tick = half_q;
         sadc_pkg::SADC_CLK_ALT: src_tick = alt_sync_q[1] && !alt_sync_q[2];
         default: src_tick = asy_sync_q[1] && !asy_sync_q[2];
      endcase
   end

   // Divide by 1, 2, 4, 8
   assign ck_tick = src_tick && (divc_q == ((8'h01 << cfg_q[sadc_pkg::SADC_DIV_LSB +: DIV_W]) - 8'h01));
   assign fin_res = fmt_result({sar_q[9:1], comp_i}, cfg_q[sadc_pkg::SADC_MODE_LSB +: 2]);
   assign cmp_true = cfgt_q ? (fin_res >= cmpv_q) : (fin_res < cmpv_q);
   assign fin = (state_q == sadc_pkg::SADC_CONVERT) && ck_tick && (bit_q == 4'h0);

   always_comb
   begin
      chan_d = chan_q;
      hwtrg_d = hwtrg_q;
      cfe_d = cfe_q;
      cfgt_d = cfgt_q;
      cmpv_d = cmpv_q;
      cfg_d = cfg_q;
      bandgap_buffer_enable_d = bandgap_buffer_enable_q;
      done_d = done_q;
      result_d = result_q;
      state_d = state_q;
      sar_d = sar_q;
      bit_d = bit_q;
      scnt_d = scnt_q;
      divc_d = src_tick ? (ck_tick ? 8'h00 : divc_q + 8'h01) : divc_q;
      half_d = !half_q;
      if (wr)
      begin
         unique case (paddr_i)
            sadc_pkg::SADC_OFF_CTRL1: chan_d = {1'b0, pwdata_i[6:0]};
            sadc_pkg::SADC_OFF_CTRL2:
            begin
               hwtrg_d = pwdata_i[sadc_pkg::SADC_HWTRG_BIT];
               cfe_d = pwdata_i[sadc_pkg::SADC_CFE_BIT];
               cfgt_d = pwdata_i[sadc_pkg::SADC_CFGT_BIT];
            end
            sadc_pkg::SADC_OFF_CMPV: cmpv_d = pwdata_i[9:0];
            sadc_pkg::SADC_OFF_CFG: cfg_d = pwdata_i[7:0];
            sadc_pkg::SADC_OFF_SYS: bandgap_buffer_enable_d = pwdata_i[sadc_pkg::SADC_BANDGAP_BUFFER_ENABLE_BIT];
            default: ;
         endcase
      end
      // Sequencer
      // Any tick source
      unique case (state_q)
         sadc_pkg::SADC_IDLE:
         begin
            if (hwtrg_q && trig_evt && !off)
            begin
               state_d = sadc_pkg::SADC_SAMPLE;
               scnt_d = '0;
            end
         end
         sadc_pkg::SADC_SAMPLE:
         begin
            if (ck_tick)
            begin
               scnt_d = scnt_q + 5'h01;
               if (scnt_q >= sample_limit(cfg_q[sadc_pkg::SADC_LSMP_BIT], cfg_q[sadc_pkg::SADC_LPWR_BIT]))
               begin
                  state_d = sadc_pkg::SADC_CONVERT;
                  sar_d = 10'h200;
                  bit_d = 4'(sadc_pkg::SADC_RES_BITS - 1);
               end
            end
         end
         sadc_pkg::SADC_CONVERT:
         begin
            if (ck_tick)
            begin
               sar_d[bit_q] = comp_i;
               if (bit_q != 4'h0)
               begin
                  sar_d[bit_q - 4'h1] = 1'b1;
                  bit_d = bit_q - 4'h1;
               end
               else
               begin
                  state_d = chan_q[sadc_pkg::SADC_CONT_BIT] ? sadc_pkg::SADC_SAMPLE : sadc_pkg::SADC_IDLE;
                  scnt_d = '0;
                  if (!cfe_q || cmp_true)
                  begin
                     result_d = fin_res;
                     done_d = 1'b1;
                  end
               end
            end
         end
         default: state_d = sadc_pkg::SADC_IDLE;
      endcase
      // Read of result clears flag, set wins
      if (rd_result && !fin)
         done_d = 1'b0;
      if (wr_chan)
      begin
         done_d = 1'b0;
         scnt_d = '0;
         state_d = (pwdata_i[4:0] == sadc_pkg::SADC_CH_OFF || hwtrg_q)
            ? sadc_pkg::SADC_IDLE : sadc_pkg::SADC_SAMPLE;
      end
   end

   always_comb
   begin
      prdata_d = '0;
      if (rd_setup)
      begin
         unique case (paddr_i)
            sadc_pkg::SADC_OFF_CTRL1: prdata_d = {24'h000000, done_q, chan_q[6:0]};
            sadc_pkg::SADC_OFF_CTRL2: prdata_d = {24'h000000, state_q != sadc_pkg::SADC_IDLE,
               hwtrg_q, cfe_q, cfgt_q, 4'h0};
            sadc_pkg::SADC_OFF_RESULT: prdata_d = {22'h000000, result_q};
            sadc_pkg::SADC_OFF_CMPV: prdata_d = {22'h000000, cmpv_q};
            sadc_pkg::SADC_OFF_CFG: prdata_d = {24'h000000, cfg_q};
            sadc_pkg::SADC_OFF_SYS: prdata_d = {31'h00000000, bandgap_buffer_enable_q};
            default: prdata_d = '0;
         endcase
      end
      dac_d = sar_d;
      sample_d = (state_d == sadc_pkg::SADC_SAMPLE);
      route_d = decode_chan(chan_d[4:0], bandgap_buffer_enable_d);
      irq_d = done_d && chan_d[sadc_pkg::SADC_IEN_BIT];
      trg_sync_d = {trg_sync_q[1:0], hw_trigger_input_i};
      alt_sync_d = {alt_sync_q[1:0], ext_reference_clock_i};
      asy_sync_d = {asy_sync_q[1:0], local_async_conv_clock_i};
      long_d = cfg_d[sadc_pkg::SADC_LSMP_BIT];
      lowp_d = cfg_d[sadc_pkg::SADC_LPWR_BIT] || (state_d == sadc_pkg::SADC_IDLE);
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         chan_q <= {3'h0, sadc_pkg::SADC_CH_OFF};
         hwtrg_q <= 1'b0;
         cfe_q <= 1'b0;
         cfgt_q <= 1'b0;
         cmpv_q <= '0;
         cfg_q <= '0;
         bandgap_buffer_enable_q <= 1'b0;
         done_q <= 1'b0;
         result_q <= '0;
         state_q <= sadc_pkg::SADC_IDLE;
         sar_q <= '0;
         bit_q <= '0;
         scnt_q <= '0;
         divc_q <= '0;
         half_q <= 1'b0;
         trg_sync_q <= '0;
         alt_sync_q <= '0;
         asy_sync_q <= '0;
         prdata_o <= '0;
         dac_code_o <= '0;
         route_o <= '{sel: sadc_pkg::SADC_CH_OFF, default: 1'b0};
         sample_o <= 1'b0;
         long_sample_o <= 1'b0;
         low_power_o <= 1'b0;
         done_irq_o <= 1'b0;
      end
      else
      begin
         chan_q <= chan_d;
         hwtrg_q <= hwtrg_d;
         cfe_q <= cfe_d;
         cfgt_q <= cfgt_d;
         cmpv_q <= cmpv_d;
         cfg_q <= cfg_d;
         bandgap_buffer_enable_q <= bandgap_buffer_enable_d;
         done_q <= done_d;
         result_q <= result_d;
         state_q <= state_d;
         sar_q <= sar_d;
         bit_q <= bit_d;
         scnt_q <= scnt_d;
         divc_q <= divc_d;
         half_q <= half_d;
         trg_sync_q <= trg_sync_d;
         alt_sync_q <= alt_sync_d;
         asy_sync_q <= asy_sync_d;
         prdata_o <= prdata_d;
         dac_code_o <= dac_d;
         route_o <= route_d;
         sample_o <= sample_d;
         long_sample_o <= long_d;
         low_power_o <= lowp_d;
         done_irq_o <= irq_d;
      end
   end

   // APB: ready is registered from the setup cycle, so every access phase lasts one cycle.
   always_comb
   begin
      rdy_d = psel_i && !penable_i;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdy_q <= 1'b0;
      end
      else
      begin
         rdy_q <= rdy_d;
      end
   end
   assign pready_o = rdy_q;
   assign pslverr_o = 1'b0;
endmodule

// ==== rtl/sadc_pkg.sv ====
// Purpose: Shared constants and types for the converter control block.
// Assumes: APB with 32-bit data; each register one aligned word.
// Notes: Offsets are byte addresses.
package sadc_pkg;
   localparam logic [11:0] SADC_OFF_CTRL1 = 12'h000;
   localparam logic [11:0] SADC_OFF_CTRL2 = 12'h004;
   localparam logic [11:0] SADC_OFF_RESULT = 12'h008;
   localparam logic [11:0] SADC_OFF_CMPV = 12'h00C;
   localparam logic [11:0] SADC_OFF_CFG = 12'h010;
   localparam logic [11:0] SADC_OFF_SYS = 12'h014;

   // Channel control register fields.
   localparam int SADC_CH_LSB = 0;
   localparam int SADC_CONT_BIT = 5;
   localparam int SADC_IEN_BIT = 6;
   localparam int SADC_DONE_BIT = 7;
   // Control register 2 fields.
   localparam int SADC_ACT_BIT = 7;
   localparam int SADC_HWTRG_BIT = 6;
   localparam int SADC_CFE_BIT = 5;
   localparam int SADC_CFGT_BIT = 4;
   // Configuration fields.
   localparam int SADC_CLKSRC_LSB = 0;
   localparam int SADC_MODE_LSB = 2;
   localparam int SADC_LSMP_BIT = 4;
   localparam int SADC_DIV_LSB = 5;
   localparam int SADC_LPWR_BIT = 7;
   // System register field.
   localparam int SADC_BANDGAP_BUFFER_ENABLE_BIT = 0;

   localparam logic [4:0] SADC_CH_LAST_PIN = 5'h0B;
   localparam logic [4:0] SADC_CH_LAST_GND = 5'h14;
   localparam logic [4:0] SADC_CH_RSV_LO = 5'h15;
   localparam logic [4:0] SADC_CH_RSV_HI = 5'h19;
   localparam logic [4:0] SADC_CH_TEMP = 5'h1A;
   localparam logic [4:0] SADC_CH_BANDGAP = 5'h1B;
   localparam logic [4:0] SADC_CH_RSV_TOP = 5'h1C;
   localparam logic [4:0] SADC_CH_VREFH = 5'h1D;
   localparam logic [4:0] SADC_CH_VREFL = 5'h1E;
   localparam logic [4:0] SADC_CH_OFF = 5'h1F;

   localparam logic [1:0] SADC_CLK_BUS = 2'h0;
   localparam logic [1:0] SADC_CLK_BUS2 = 2'h1;
   localparam logic [1:0] SADC_CLK_ALT = 2'h2;
   localparam logic [1:0] SADC_CLK_ASYNC = 2'h3;
   localparam logic [1:0] SADC_MODE_8 = 2'h0;
   localparam logic [1:0] SADC_MODE_10 = 2'h2;

   localparam int SADC_RES_BITS = 10;
   localparam logic [4:0] SADC_SAMPLE_SHORT = 5'h03;
   localparam logic [4:0] SADC_SAMPLE_LONG = 5'h17;
   localparam logic [4:0] SADC_EXTRA_HISPD = 5'h02;

   typedef enum logic [2:0] {
      SADC_IDLE = 3'b001,
      SADC_SAMPLE = 3'b010,
      SADC_CONVERT = 3'b100
   } sadc_state_type;

   typedef struct packed {
      logic [9:0] data;
      logic valid;
   } sadc_sample_type;

   typedef struct packed {
      logic [4:0] sel;
      logic pin_en;
      logic gnd_en;
      logic temp_en;
      logic bandgap_en;
      logic vrefh_en;
      logic vrefl_en;
      logic powered;
   } sadc_route_type;
endpackage

// ==== tb/sadc_analog_model.sv ====
// Purpose: Analog inputs, clock sources and counter overflow for the bench.
// Assumes: Comparator high while the input is at or above the trial code.
// Notes: Unpowered, the comparator answer toggles every cycle.
module sadc_analog_model (
   // Clock
   input wire logic clk_i,
   // Converter side
   input wire logic [9:0] dac_code_i,
   input wire sadc_pkg::sadc_route_type route_i,
   input wire logic fire_i,
   output logic comp_o,
   output logic ext_clk_o,
   output logic async_clk_o,
   output logic trig_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] level;
   logic idle_q = 1'b0;
   initial
   begin
      ext_clk_o = 1'b0;
      forever #20 ext_clk_o = ~ext_clk_o;
   end
   initial
   begin
      async_clk_o = 1'b0;
      forever #13 async_clk_o = ~async_clk_o;
   end
   always @(posedge clk_i) idle_q <= ~idle_q;
   always_comb level = route_i.pin_en ? {route_i.sel, 5'h15} : route_i.vrefh_en ? 10'h3FF :
      route_i.temp_en ? 10'h1C3 : route_i.bandgap_en ? 10'h171 : 10'h000;
   assign comp_o = route_i.powered ? (level >= dac_code_i) : idle_q;
   assign trig_o = fire_i;
endmodule

// ==== tb/sadc_ctrl_monitor.sv ====
// Purpose: Port checker for the converter control block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every instance of the control block.
module sadc_ctrl_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Converter side
   input wire logic sample_o,
   input wire sadc_pkg::sadc_route_type route_o,
   input wire logic done_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   logic acc, wr1, clr;
   logic [4:0] sel_d, sel_q;
   assign acc = psel_i && penable_i && pready_o;
   assign wr1 = acc && pwrite_i && paddr_i == sadc_pkg::SADC_OFF_CTRL1;
   assign clr = wr1 || (acc && !pwrite_i && paddr_i == sadc_pkg::SADC_OFF_RESULT);
   always_comb sel_d = wr1 ? pwdata_i[4:0] : sel_q;
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         sel_q <= 5'h1F;
      else
         sel_q <= sel_d;
   sequence ctrl_write;
      wr1;
   endsequence
   sequence sel_landed;
      ##[1:2] route_o.sel == sel_q;
   endsequence
   chk_bus_ready: assert property (psel_i && penable_i |-> pready_o && !pslverr_o) else $error("bus answer wrong");
   chk_setup_wait: assert property (psel_i && !penable_i |-> !pready_o) else $error("ready in setup cycle");
   chk_sel_follow: assert property (ctrl_write |-> sel_landed) else $error("channel not taken");
   chk_off_dark: assert property (route_o.sel == 5'h1F |-> !route_o.powered && !route_o.pin_en)
      else $error("off channel powered");
   chk_pin_route: assert property (route_o.powered && route_o.sel <= 5'h0B |-> route_o.pin_en && !route_o.gnd_en)
      else $error("pin not routed");
   chk_gnd_route: assert property (route_o.powered && route_o.sel inside {[5'h0C:5'h14]} |-> route_o.gnd_en)
      else $error("ground not routed");
   chk_temp_route: assert property (route_o.powered && route_o.sel == 5'h1A |-> route_o.temp_en)
      else $error("sensor not routed");
   chk_high_ref: assert property (route_o.powered && route_o.sel == 5'h1D |-> route_o.vrefh_en && !route_o.vrefl_en)
      else $error("high ref not routed");
   chk_low_ref: assert property (route_o.powered && route_o.sel == 5'h1E |-> route_o.vrefl_en)
      else $error("low ref not routed");
   chk_bandgap_sel: assert property (route_o.bandgap_en |-> route_o.sel == 5'h1B) else $error("stray bandgap");
   chk_no_sample: assert property (sample_o |-> route_o.sel != 5'h1F) else $error("sampling while off");
   chk_irq_clear: assert property ($fell(done_irq_o) |-> $past(clr) || $past(clr, 2))
      else $error("irq dropped alone");
endmodule
bind sadc_ctrl sadc_ctrl_monitor sadc_ctrl_monitor_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .sample_o(sample_o), .route_o(route_o), .done_irq_o(done_irq_o));

// ==== tb/sadc_ctrl_tb.sv ====
// Purpose: Self-checking bench for the converter control block.
// Assumes: Read data is taken at the same rising edge that samples ready high.
// Notes: Pin k reads as {k, 5'h15} from the analog model.
module sadc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, comp_i, ext_clk, async_clk, trig, fire;
   logic done_irq_o, long_smp, low_pwr;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, q;
   logic [9:0] dac_code_o;
   sadc_pkg::sadc_route_type route_o;
   int errors, check_count;
   sadc_ctrl sadc_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .ext_reference_clock_i(ext_clk), .local_async_conv_clock_i(async_clk),
      .hw_trigger_input_i(trig), .comp_i(comp_i), .dac_code_o(dac_code_o), .route_o(route_o), .sample_o(),
      .long_sample_o(long_smp), .low_power_o(low_pwr), .done_irq_o(done_irq_o));
   sadc_analog_model sadc_analog_model_inst (.clk_i(clk_i), .dac_code_i(dac_code_o), .route_i(route_o),
      .fire_i(fire), .comp_o(comp_i), .ext_clk_o(ext_clk), .async_clk_o(async_clk), .trig_o(trig));
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic wrap_up;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 50);
      chk("pready", pready_o, 1'b1);
      if (n >= 50)
         wrap_up();
      q = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wait_done(input int lim, output logic hit);
      hit = 1'b0;
      for (int n = 0; n < lim && !hit; n++)
      begin
         apb(1'b0, sadc_pkg::SADC_OFF_CTRL1, 32'h0);
         hit = q[sadc_pkg::SADC_DONE_BIT] === 1'b1;
      end
   endtask
   task automatic t_reset;
      apb(1'b0, sadc_pkg::SADC_OFF_CTRL1, 32'h0);
      chk("ctrl1", q, 32'h1F);
      chk("power", route_o.powered, 1'b0);
      apb(1'b1, 12'h020, 32'hFFFFFFFF);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped", q, 32'h0);
   endtask
   task automatic t_routes;
      logic [5:0] e;
      for (int c = 0; c < 32; c++)
      begin
         apb(1'b1, sadc_pkg::SADC_OFF_CTRL1, c);
         @(posedge clk_i);
         e = {c <= 11, c >= 12 && c <= 20, c == 26, c == 27, c == 29, c == 30};
         chk("route", {route_o.sel, route_o[6:1]}, {c[4:0], e});
      end
      chk("off", route_o.powered, 1'b0);
   endtask
   task automatic t_conv(input logic [7:0] cfg, input logic [7:0] c2, input logic [7:0] c1, input logic [9:0] exp,
      input logic want);
      logic hit;
      apb(1'b1, sadc_pkg::SADC_OFF_CFG, {24'h0, cfg});
      chk("long", long_smp, cfg[sadc_pkg::SADC_LSMP_BIT]);
      chk("low power", low_pwr, 1'b1);
      apb(1'b1, sadc_pkg::SADC_OFF_CTRL2, {24'h0, c2});
      apb(1'b1, sadc_pkg::SADC_OFF_CTRL1, {24'h0, c1});
      if (c2[sadc_pkg::SADC_HWTRG_BIT])
      begin
         wait_done(20, hit);
         chk("armed", hit, 1'b0);
         fire <= 1'b1;
         repeat (6) @(posedge clk_i);
         fire <= 1'b0;
      end
      wait_done(want ? 800 : 300, hit);
      chk("done", hit, want);
      if (want && !hit)
         wrap_up();
      if (want)
      begin
         chk("irq", done_irq_o, c1[sadc_pkg::SADC_IEN_BIT]);
         apb(1'b0, sadc_pkg::SADC_OFF_RESULT, 32'h0);
         chk("result", q, {22'h0, exp});
         apb(1'b0, sadc_pkg::SADC_OFF_CTRL1, 32'h0);
         chk("cleared", q[sadc_pkg::SADC_DONE_BIT], 1'b0);
         chk("irq off", done_irq_o, 1'b0);
         apb(1'b0, sadc_pkg::SADC_OFF_CTRL2, 32'h0);
         chk("active", q[sadc_pkg::SADC_ACT_BIT], c1[sadc_pkg::SADC_CONT_BIT]);
         chk("busy power", low_pwr, cfg[sadc_pkg::SADC_LPWR_BIT] | !c1[sadc_pkg::SADC_CONT_BIT]);
      end
      if (c1[sadc_pkg::SADC_CONT_BIT])
      begin
         wait_done(800, hit);
         chk("repeat", hit, 1'b1);
         apb(1'b1, sadc_pkg::SADC_OFF_CTRL1, 32'h1F);
         wait_done(60, hit);
         chk("no extra", hit, 1'b0);
      end
   endtask
   initial
   begin
      rstn_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      fire = 1'b0;
      errors = 0;
      check_count = 0;
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      apb(1'b1, sadc_pkg::SADC_OFF_SYS, 32'h1);
      t_routes();
      for (int s = 0; s < 4; s++)
         t_conv(8'h08 | s[7:0], 8'h00, 8'h45, 10'h0B5, 1'b1);
      t_conv(8'h60, 8'h00, 8'h05, 10'h02D, 1'b1);
      t_conv(8'h98, 8'h00, 8'h1B, 10'h171, 1'b1);
      t_conv(8'h98, 8'h00, 8'h1A, 10'h1C3, 1'b1);
      t_conv(8'h08, 8'h00, 8'h1D, 10'h3FF, 1'b1);
      t_conv(8'h08, 8'h00, 8'h0C, 10'h000, 1'b1);
      apb(1'b1, sadc_pkg::SADC_OFF_CMPV, 32'h100);
      t_conv(8'h08, 8'h20, 8'h05, 10'h0B5, 1'b1);
      t_conv(8'h08, 8'h30, 8'h05, 10'h000, 1'b0);
      t_conv(8'h08, 8'h40, 8'h45, 10'h0B5, 1'b1);
      t_conv(8'h08, 8'h00, 8'h25, 10'h0B5, 1'b1);
      wrap_up();
   end
endmodule
